/* hdl/bcc_clock.sv */
`timescale 1ns/100ps
`default_nettype none
module bcc_clock
    import bcc_pkg::*;
(
    input  wire logic       sys_clk,       // System clock, 200 MHz.
    input  wire logic       reset_n,       // Asynchronous reset, active low.
    input  wire logic [7:0] sfr_addr,      // Special-function register address.
    input  wire logic       sfr_wr,        // Write strobe, one cycle.
    input  wire logic       sfr_rd,        // Read strobe, one cycle.
    input  wire logic [7:0] sfr_wdata,     // Write data.
    output logic      [7:0] sfr_rdata,     // Read data, one cycle after address.
    input  wire logic       half_sec_tick, // Half-second timekeeping pulse.
    output logic            irq,           // Interrupt request, level.
    output logic      [7:0] irq_vector     // Interrupt vector address.
);

    // ========================================================================
    // Register state.
    logic [7:0] index_sel;
    logic [7:0] ctrl;
    bcc_time_t  now;
    bcc_time_t  next_now;
    logic [7:0] alm_min;
    logic [7:0] alm_hour;
    logic [7:0] alm_day;
    logic [7:0] alm_week;
    logic [7:0] alm_month;
    logic       half_phase;
    logic [12:0] per_cnt;
    logic [12:0] per_len;
    logic       match_d;

    logic       data_wr;
    logic       run;
    logic       sec_tick;
    logic       per_fire;
    logic       match_now;
    logic       match_rise;
    logic [7:0] window_val;

    // Increments a BCD value, wrapping from its maximum back to its minimum.
    function automatic logic [7:0] bcd_inc(input logic [7:0] v,
                                           input logic [7:0] maxv,
                                           input logic [7:0] minv);
        logic [7:0] r;
        r = 8'h00;
        if (v == maxv) begin
            r = minv;
        end else if (v[3:0] == 4'h9) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = v + 8'h01;
        end
        return r;
    endfunction

    assign data_wr  = sfr_wr && (sfr_addr == BCC_SFR_DATA);
    assign run      = ctrl[BCC_CTRL_RUN];
    assign sec_tick = half_sec_tick && run && half_phase;

    // ========================================================================
    // Index register and interrupt vector.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            index_sel <= BCC_RST_ZERO;
        end else if (sfr_wr && (sfr_addr == BCC_SFR_INDEX)) begin
            index_sel <= sfr_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_vector <= BCC_IRQ_VECTOR;
        end else begin
            irq_vector <= BCC_IRQ_VECTOR;
        end
    end

    // ========================================================================
    // Half-second phase; two ticks make one second.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            half_phase <= 1'b0;
        end else if (!run) begin
            half_phase <= 1'b0;
        end else if (half_sec_tick) begin
            half_phase <= !half_phase;
        end
    end

    // ========================================================================
    // Calendar counters: software writes win over the carry chain.
    always_comb begin
        next_now = now;
        if (sec_tick) begin
            next_now.sec = 7'(bcd_inc({1'b0, now.sec}, BCC_MAX_SEC, BCC_RST_ZERO));
            if ({1'b0, now.sec} == BCC_MAX_SEC) begin
                next_now.min = 7'(bcd_inc({1'b0, now.min}, BCC_MAX_SEC, BCC_RST_ZERO));
                if ({1'b0, now.min} == BCC_MAX_SEC) begin
                    next_now.hour = 6'(bcd_inc({2'b00, now.hour}, BCC_MAX_HOUR,
                                               BCC_RST_ZERO));
                    if ({2'b00, now.hour} == BCC_MAX_HOUR) begin
                        next_now.day = 6'(bcd_inc({2'b00, now.day}, BCC_MAX_DAY,
                                                  BCC_MIN_DAY));
                        if ({2'b00, now.day} == BCC_MAX_DAY) begin
                            next_now.month = 5'(bcd_inc({3'b000, now.month},
                                                        BCC_MAX_MONTH,
                                                        BCC_MIN_MONTH));
                            if ({3'b000, now.month} == BCC_MAX_MONTH) begin
                                next_now.year = bcd_inc(now.year, BCC_MAX_YEAR,
                                                        BCC_RST_ZERO);
                            end
                        end
                    end
                end
            end
        end
        if (data_wr) begin
            case (index_sel)
                BCC_IX_SEC:   next_now.sec   = sfr_wdata[6:0];
                BCC_IX_MIN:   next_now.min   = sfr_wdata[6:0];
                BCC_IX_HOUR:  next_now.hour  = sfr_wdata[5:0];
                BCC_IX_DAY:   next_now.day   = sfr_wdata[5:0];
                BCC_IX_WEEK:  next_now.week  = sfr_wdata[2:0];
                BCC_IX_MONTH: next_now.month = sfr_wdata[4:0];
                BCC_IX_YEAR:  next_now.year  = sfr_wdata;
                default:      next_now.year  = next_now.year;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            now.year  <= BCC_RST_ZERO;
            now.month <= BCC_RST_MONTH[4:0];
            now.week  <= BCC_RST_WEEK[2:0];
            now.day   <= BCC_RST_DAY[5:0];
            now.hour  <= BCC_RST_ZERO[5:0];
            now.min   <= BCC_RST_ZERO[6:0];
            now.sec   <= BCC_RST_ZERO[6:0];
        end else begin
            now <= next_now;
        end
    end

    // ========================================================================
    // Alarm registers.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            alm_min   <= BCC_RST_ZERO;
            alm_hour  <= BCC_RST_ZERO;
            alm_day   <= BCC_RST_ZERO;
            alm_week  <= BCC_RST_ZERO;
            alm_month <= BCC_RST_ZERO;
        end else if (data_wr) begin
            case (index_sel)
                BCC_IX_AMIN:   alm_min   <= sfr_wdata;
                BCC_IX_AHOUR:  alm_hour  <= {sfr_wdata[7], 1'b0, sfr_wdata[5:0]};
                BCC_IX_ADAY:   alm_day   <= {sfr_wdata[7], 1'b0, sfr_wdata[5:0]};
                BCC_IX_AWEEK:  alm_week  <= {sfr_wdata[7], 4'h0, sfr_wdata[2:0]};
                BCC_IX_AMONTH: alm_month <= {sfr_wdata[7], 2'b00, sfr_wdata[4:0]};
                default:       alm_min   <= alm_min;
            endcase
        end
    end

    // A disabled field always counts as matching; with no field enabled the
    // comparator never fires, so an idle alarm cannot flood the flag.
    always_comb begin
        match_now = (alm_min[BCC_ALM_EN] || alm_hour[BCC_ALM_EN]
                     || alm_day[BCC_ALM_EN] || alm_week[BCC_ALM_EN]
                     || alm_month[BCC_ALM_EN])
            && (!alm_min[BCC_ALM_EN]   || (alm_min[6:0]   == now.min))
            && (!alm_hour[BCC_ALM_EN]  || (alm_hour[5:0]  == now.hour))
            && (!alm_day[BCC_ALM_EN]   || (alm_day[5:0]   == now.day))
            && (!alm_week[BCC_ALM_EN]  || (alm_week[2:0]  == now.week))
            && (!alm_month[BCC_ALM_EN] || (alm_month[4:0] == now.month));
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            match_d <= 1'b0;
        end else begin
            match_d <= match_now;
        end
    end

    assign match_rise = match_now && !match_d && ctrl[BCC_CTRL_AIE];

    // ========================================================================
    // Periodic interval counter.
    always_comb begin
        case (ctrl[2:0])
            3'h0:    per_len = BCC_PER_HALF_S;
            3'h1:    per_len = BCC_PER_1_S;
            3'h2:    per_len = BCC_PER_HALF_M;
            3'h3:    per_len = BCC_PER_1_M;
            3'h4:    per_len = BCC_PER_HALF_H;
            default: per_len = BCC_PER_1_H;
        endcase
    end

    assign per_fire = half_sec_tick && run && ctrl[BCC_CTRL_PIE]
                      && ((per_cnt + 13'h0001) >= per_len) && !data_wr;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            per_cnt <= 13'h0000;
        end else if (data_wr || !ctrl[BCC_CTRL_PIE]) begin
            per_cnt <= 13'h0000;
        end else if (half_sec_tick && run) begin
            if ((per_cnt + 13'h0001) >= per_len) begin
                per_cnt <= 13'h0000;
            end else begin
                per_cnt <= per_cnt + 13'h0001;
            end
        end
    end

    // ========================================================================
    // Control register; flags clear on a written 0, an alarm hardware set wins, and the interval flag cannot set during a data write.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= BCC_RST_ZERO;
        end else begin
            if (data_wr && (index_sel == BCC_IX_CTRL)) begin
                ctrl[BCC_CTRL_RUN] <= sfr_wdata[BCC_CTRL_RUN];
                ctrl[BCC_CTRL_AIE] <= sfr_wdata[BCC_CTRL_AIE];
                ctrl[BCC_CTRL_PIE] <= sfr_wdata[BCC_CTRL_PIE];
                ctrl[2:0]          <= sfr_wdata[2:0];
                ctrl[BCC_CTRL_PIF] <= per_fire
                    || (ctrl[BCC_CTRL_PIF] && sfr_wdata[BCC_CTRL_PIF]);
                ctrl[BCC_CTRL_AIF] <= match_rise
                    || (ctrl[BCC_CTRL_AIF] && sfr_wdata[BCC_CTRL_AIF]);
            end else begin
                ctrl[BCC_CTRL_PIF] <= ctrl[BCC_CTRL_PIF] || per_fire;
                ctrl[BCC_CTRL_AIF] <= ctrl[BCC_CTRL_AIF] || match_rise;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= ctrl[BCC_CTRL_PIF] || ctrl[BCC_CTRL_AIF];
        end
    end

    // ========================================================================
    // Read path.
    always_comb begin
        case (index_sel)
            BCC_IX_CTRL:   window_val = ctrl;
            BCC_IX_SEC:    window_val = {1'b0, now.sec};
            BCC_IX_MIN:    window_val = {1'b0, now.min};
            BCC_IX_HOUR:   window_val = {2'b00, now.hour};
            BCC_IX_DAY:    window_val = {2'b00, now.day};
            BCC_IX_WEEK:   window_val = {5'h00, now.week};
            BCC_IX_MONTH:  window_val = {3'h0, now.month};
            BCC_IX_YEAR:   window_val = now.year;
            BCC_IX_AMIN:   window_val = alm_min;
            BCC_IX_AHOUR:  window_val = alm_hour;
            BCC_IX_ADAY:   window_val = alm_day;
            BCC_IX_AWEEK:  window_val = alm_week;
            BCC_IX_AMONTH: window_val = alm_month;
            default:       window_val = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_addr == BCC_SFR_INDEX) begin
            sfr_rdata <= index_sel;
        end else if (sfr_addr == BCC_SFR_DATA) begin
            sfr_rdata <= window_val;
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

    // ========================================================================
    // Assertions.
    a_vector_fixed: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ##1 irq_vector == 8'h8B)
        else $error("interrupt vector is not 8BH");

    a_index_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (data_wr && index_sel == BCC_IX_YEAR) |=> now.year == $past(sfr_wdata))
        else $error("data window write missed the indexed year register");

    a_stopped_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!run && !data_wr) |=> $stable(now))
        else $error("time moved while stopped");

    a_pflag_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (ctrl[BCC_CTRL_PIF] && !data_wr) |=> ctrl[BCC_CTRL_PIF])
        else $error("interval flag dropped without a write");

    a_alarm_gated: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(ctrl[BCC_CTRL_AIF]) |-> $past(ctrl[BCC_CTRL_AIE]) && $past(match_now))
        else $error("alarm flag rose without enable and match");

    a_period_gated: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(ctrl[BCC_CTRL_PIF]) |-> $past(ctrl[BCC_CTRL_PIE]) && $past(run))
        else $error("interval flag rose while interval disabled");

    a_min_carry: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (sec_tick && !data_wr && now.sec == 7'h59 && now.min == 7'h10)
        |=> now.sec == 7'h00 && now.min == 7'h11)
        else $error("seconds did not carry into minutes");

    a_hour_wrap: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (sec_tick && !data_wr && now.sec == 7'h59 && now.min == 7'h59
         && now.hour == 6'h23) |=> now.hour == 6'h00)
        else $error("hour did not wrap after 23");

    a_week_still: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !data_wr |=> $stable(now.week))
        else $error("weekday changed without a write");

    a_one_sec: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (per_fire && ctrl[2:0] == 3'h1) |-> per_cnt == 13'h0001)
        else $error("one second interval fired at the wrong count");

endmodule
`default_nettype wire

/* include/bcc_pkg.sv */
`default_nettype none
package bcc_pkg;
    // ========================================================================
    // Special-function window and interrupt vector.
    localparam logic [7:0] BCC_SFR_INDEX   = 8'h9E;
    localparam logic [7:0] BCC_SFR_DATA    = 8'h9F;
    localparam logic [7:0] BCC_IRQ_VECTOR  = 8'h8B;
    // ========================================================================
    // Indexed register map.
    localparam logic [7:0] BCC_IX_CTRL     = 8'h00;
    localparam logic [7:0] BCC_IX_SEC      = 8'h01;
    localparam logic [7:0] BCC_IX_MIN      = 8'h02;
    localparam logic [7:0] BCC_IX_HOUR     = 8'h03;
    localparam logic [7:0] BCC_IX_DAY      = 8'h04;
    localparam logic [7:0] BCC_IX_WEEK     = 8'h05;
    localparam logic [7:0] BCC_IX_MONTH    = 8'h06;
    localparam logic [7:0] BCC_IX_YEAR     = 8'h07;
    localparam logic [7:0] BCC_IX_AMIN     = 8'h08;
    localparam logic [7:0] BCC_IX_AHOUR    = 8'h09;
    localparam logic [7:0] BCC_IX_ADAY     = 8'h10;
    localparam logic [7:0] BCC_IX_AWEEK    = 8'h11;
    localparam logic [7:0] BCC_IX_AMONTH   = 8'h12;
    // ========================================================================
    // Control register fields.
    localparam int BCC_CTRL_RUN  = 7;
    localparam int BCC_CTRL_PIF  = 6;
    localparam int BCC_CTRL_AIE  = 5;
    localparam int BCC_CTRL_AIF  = 4;
    localparam int BCC_CTRL_PIE  = 3;
    localparam int BCC_ALM_EN    = 7;
    // ========================================================================
    // Reset values and BCD field limits.
    localparam logic [7:0] BCC_RST_ZERO    = 8'h00;
    localparam logic [7:0] BCC_RST_DAY     = 8'h01;
    localparam logic [7:0] BCC_RST_WEEK    = 8'h06;
    localparam logic [7:0] BCC_RST_MONTH   = 8'h01;
    localparam logic [7:0] BCC_MAX_SEC     = 8'h59;
    localparam logic [7:0] BCC_MAX_HOUR    = 8'h23;
    localparam logic [7:0] BCC_MAX_DAY     = 8'h31;
    localparam logic [7:0] BCC_MIN_DAY     = 8'h01;
    localparam logic [7:0] BCC_MAX_MONTH   = 8'h12;
    localparam logic [7:0] BCC_MIN_MONTH   = 8'h01;
    localparam logic [7:0] BCC_MAX_YEAR    = 8'h99;
    // ========================================================================
    // Periodic intervals counted in half-second ticks.
    localparam logic [12:0] BCC_PER_HALF_S = 13'h0001;
    localparam logic [12:0] BCC_PER_1_S    = 13'h0002;
    localparam logic [12:0] BCC_PER_HALF_M = 13'h003C;
    localparam logic [12:0] BCC_PER_1_M    = 13'h0078;
    localparam logic [12:0] BCC_PER_HALF_H = 13'h0E10;
    localparam logic [12:0] BCC_PER_1_H    = 13'h1C20;

    typedef struct packed {
        logic [7:0] year;
        logic [4:0] month;
        logic [2:0] week;
        logic [5:0] day;
        logic [5:0] hour;
        logic [6:0] min;
        logic [6:0] sec;
    } bcc_time_t;
endpackage
`default_nettype wire

/* bench/tb_bcc_clock.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_bcc_clock;
    import bcc_pkg::*;

    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] rst;
        logic [7:0] wval;
        logic [7:0] exp;
    } bcc_row_t;

    logic       sys_clk;
    logic       reset_n;
    logic [7:0] sfr_addr;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic       half_sec_tick;
    logic       irq;
    logic [7:0] irq_vector;
    logic [7:0] rv;
    int         bad_count;
    int         n_compared;

    // Index, reset value, value written, value read back.
    bcc_row_t rows [14] = '{
        '{BCC_IX_SEC,    8'h00, 8'h59, 8'h59},
        '{BCC_IX_MIN,    8'h00, 8'h59, 8'h59},
        '{BCC_IX_HOUR,   8'h00, 8'h23, 8'h23},
        '{BCC_IX_DAY,    8'h01, 8'h31, 8'h31},
        '{BCC_IX_WEEK,   8'h06, 8'hFE, 8'h06},
        '{BCC_IX_MONTH,  8'h01, 8'h12, 8'h12},
        '{BCC_IX_YEAR,   8'h00, 8'h99, 8'h99},
        '{BCC_IX_AMIN,   8'h00, 8'hD9, 8'hD9},
        '{BCC_IX_AHOUR,  8'h00, 8'hA3, 8'hA3},
        '{BCC_IX_ADAY,   8'h00, 8'hA1, 8'hA1},
        '{BCC_IX_AWEEK,  8'h00, 8'h86, 8'h86},
        '{BCC_IX_AMONTH, 8'h00, 8'h92, 8'h92},
        '{8'h0F,         8'h00, 8'h55, 8'h00},
        '{BCC_IX_CTRL,   8'h00, 8'h00, 8'h00}
    };
    logic [12:0] per_cnt [6] = '{BCC_PER_HALF_S, BCC_PER_1_S, BCC_PER_HALF_M,
                                 BCC_PER_1_M, BCC_PER_HALF_H, BCC_PER_1_H};

    bcc_clock bcc_clock_i (
        .sys_clk       (sys_clk),
        .reset_n       (reset_n),
        .sfr_addr      (sfr_addr),
        .sfr_wr        (sfr_wr),
        .sfr_rd        (sfr_rd),
        .sfr_wdata     (sfr_wdata),
        .sfr_rdata     (sfr_rdata),
        .half_sec_tick (half_sec_tick),
        .irq           (irq),
        .irq_vector    (irq_vector)
    );

    always #2.5 sys_clk = ~sys_clk;

    // ========================================================================
    // Bus and comparison tasks.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic sfr_put(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge sys_clk);
        sfr_wr    <= 1'b0;
    endtask

    task automatic reg_put(input logic [7:0] idx, input logic [7:0] d);
        sfr_put(BCC_SFR_INDEX, idx);
        sfr_put(BCC_SFR_DATA, d);
    endtask

    task automatic reg_get(input logic [7:0] idx, output logic [7:0] v);
        sfr_put(BCC_SFR_INDEX, idx);
        @(posedge sys_clk);
        sfr_addr <= BCC_SFR_DATA;
        sfr_rd   <= 1'b1;
        @(posedge sys_clk);
        sfr_rd   <= 1'b0;
        @(posedge sys_clk);
        #1 v = sfr_rdata;
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            half_sec_tick <= 1'b1;
            @(posedge sys_clk);
            half_sec_tick <= 1'b0;
        end
    endtask

    task automatic irq_is(input logic e, input string what);
        repeat (2) @(posedge sys_clk);
        #1 check({7'h00, irq}, {7'h00, e}, what);
    endtask

    // Stops, presets 10:58 with the given hour alarm and weekday alarm, runs 4 ticks.
    task automatic alarm_run(input logic [7:0] ah, input logic [7:0] aw,
                             input logic [7:0] c, input logic [7:0] ec);
        reg_put(BCC_IX_CTRL, 8'h00);
        reg_put(BCC_IX_AHOUR, ah);
        reg_put(BCC_IX_AWEEK, aw);
        reg_put(BCC_IX_SEC, 8'h58);
        reg_put(BCC_IX_MIN, 8'h10);
        reg_put(BCC_IX_CTRL, c);
        ticks(4);
        irq_is(ec[BCC_CTRL_AIF], "alarm irq");
        reg_get(BCC_IX_CTRL, rv);
        check(rv, ec, "alarm flag");
    endtask

    task automatic test_done;
        $display("compared %0d, mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge sys_clk);
        bad_count++;
        test_done;
    end

    // ========================================================================
    // Main sequence.
    initial begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
        half_sec_tick = 1'b0;
        bad_count = 0;
        n_compared = 0;
        repeat (3) @(posedge sys_clk);
        #1 check(irq_vector, 8'h8B, "vector");
        check({7'h00, irq}, 8'h00, "irq in reset");
        @(posedge sys_clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            reg_get(rows[i].idx, rv);
            check(rv, rows[i].rst, "reset value");
            reg_put(rows[i].idx, rows[i].wval);
            reg_get(rows[i].idx, rv);
            check(rv, rows[i].exp, "read back");
        end
        $display("register table test done");

        reg_put(BCC_IX_SEC, 8'h59);
        reg_put(BCC_IX_CTRL, 8'h80);
        ticks(2);
        foreach (rows[i]) begin
            if (i < 7) begin
                reg_get(rows[i].idx, rv);
                check(rv, (i == 4) ? 8'h06 : rows[i].rst, "full carry");
            end
        end
        reg_put(BCC_IX_CTRL, 8'h00);
        ticks(4);
        reg_get(BCC_IX_SEC, rv);
        check(rv, 8'h00, "stopped clock");
        $display("carry test done");

        for (int s = 0; s < 6; s++) begin
            reg_put(BCC_IX_CTRL, 8'h88 | 8'(s));
            ticks(int'(per_cnt[s]) - 1);
            reg_put(BCC_IX_CTRL, 8'h88 | 8'(s));
            ticks(int'(per_cnt[s]) - 1);
            reg_get(BCC_IX_CTRL, rv);
            check(rv, 8'h88 | 8'(s), "interval early");
            ticks(1);
            irq_is(1'b1, "interval irq");
            reg_put(BCC_IX_CTRL, 8'hC8 | 8'(s));
            reg_get(BCC_IX_CTRL, rv);
            check(rv, 8'hC8 | 8'(s), "interval flag kept");
            reg_put(BCC_IX_CTRL, 8'h88 | 8'(s));
            reg_get(BCC_IX_CTRL, rv);
            check(rv, 8'h88 | 8'(s), "interval flag cleared");
            irq_is(1'b0, "interval irq cleared");
        end
        reg_put(BCC_IX_CTRL, 8'h80);
        ticks(4);
        reg_get(BCC_IX_CTRL, rv);
        check(rv, 8'h80, "interval disabled");
        $display("interval test done");

        reg_put(BCC_IX_HOUR, 8'h07);
        reg_put(BCC_IX_AMIN, 8'h91);
        reg_put(BCC_IX_ADAY, 8'h00);
        reg_put(BCC_IX_AMONTH, 8'h05);
        alarm_run(8'h87, 8'h05, 8'hA0, 8'hB0);
        reg_put(BCC_IX_CTRL, 8'hA0);
        irq_is(1'b0, "alarm cleared");
        alarm_run(8'h88, 8'h05, 8'hA0, 8'hA0);
        alarm_run(8'h07, 8'h86, 8'hA0, 8'hB0);
        alarm_run(8'h07, 8'h85, 8'hA0, 8'hA0);
        alarm_run(8'h87, 8'h05, 8'h80, 8'h80);
        $display("alarm test done");

        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        reg_get(BCC_IX_HOUR, rv);
        check(rv, 8'h00, "hour after reset");
        check(irq_vector, 8'h8B, "vector after reset");
        $display("second reset test done");
        test_done;
    end
endmodule
`default_nettype wire
